/* shared/iopc_map.svh */
// Constants for the pin port control block: codes, widths, layouts
`ifndef IOPC_MAP_SVH
`define IOPC_MAP_SVH
// ==================================================
// Drive codes
`define IOPC_DM_ANALOG_HIZ   3'h0
`define IOPC_DM_DIGITAL_HIZ  3'h1
`define IOPC_DM_RES_UP       3'h2
`define IOPC_DM_RES_DOWN     3'h3
`define IOPC_DM_OD_LOW       3'h4
`define IOPC_DM_OD_HIGH      3'h5
`define IOPC_DM_STRONG       3'h6
`define IOPC_DM_RES_BOTH     3'h7
// ==================================================
// Reset values
`define IOPC_RST_DM          3'h0
`define IOPC_RST_BYTE        8'h00
// ==================================================
// Edge select codes
`define IOPC_EDGE_NONE       2'h0
`define IOPC_EDGE_RISE       2'h1
`define IOPC_EDGE_FALL       2'h2
`define IOPC_EDGE_BOTH       2'h3
// ==================================================
// Pin form register layout (one byte per pin)
`define IOPC_PF_OUT          0
`define IOPC_PF_DM_LO        1
`define IOPC_PF_DM_HI        3
`define IOPC_PF_IBUF_DIS     4
`define IOPC_PF_SLOW         5
`define IOPC_PF_BYPASS       6
`define IOPC_PF_REG_HIGH     7
// ==================================================
// Port form selectors
`define IOPC_SEL_OUT         3'h0
`define IOPC_SEL_DM0         3'h1
`define IOPC_SEL_DM1         3'h2
`define IOPC_SEL_DM2         3'h3
`define IOPC_SEL_IBUF_DIS    3'h4
`define IOPC_SEL_SLOW        3'h5
`define IOPC_SEL_BYPASS      3'h6
`define IOPC_SEL_REG_HIGH    3'h7
// ==================================================
// Threshold codes
`define IOPC_VT_HALF_SUPPLY  2'h0
`define IOPC_VT_0P4_SUPPLY   2'h1
`define IOPC_VT_HALF_REF     2'h2
`define IOPC_VT_FULL_REF     2'h3
`endif

/* shared/iopc_pkg.sv */
// Types for the pin port control block
package iopc_pkg;
  // ==================================================
  // Pin drive behaviour
  typedef enum logic [2:0] {
    IOPC_ANALOG_HIZ  = 3'b000,
    IOPC_DIGITAL_HIZ = 3'b001,
    IOPC_RES_UP      = 3'b010,
    IOPC_RES_DOWN    = 3'b011,
    IOPC_OD_LOW      = 3'b100,
    IOPC_OD_HIGH     = 3'b101,
    IOPC_STRONG      = 3'b110,
    IOPC_RES_BOTH    = 3'b111
  } iopc_drive_t;
  // Edge detect selection
  typedef enum logic [1:0] {
    IOPC_E_NONE = 2'b00,
    IOPC_E_RISE = 2'b01,
    IOPC_E_FALL = 2'b10,
    IOPC_E_BOTH = 2'b11
  } iopc_edge_t;
endpackage

/* rtl/iopc_port.sv */
// One eight-pin port: drive control, bidirectional enable, edge flags
// ==================================================
// What this block does
// - Three-bit code selects eight drive behaviours
// - Reset puts every pin analog high-Z
// - Digital high-Z: driver off, input on
// - Single pull modes: resistor one way, strong other
// - Open drain: float one value, drive other
// - Strong mode drives both levels actively
// - Combined mode: resistor up and down
// - No pull codes on regulated special pins
// - Port form writes set all pins at once, except a pin given a pin form write in the same cycle
// - Pin form shares the same settings
// - Routed enable toggles input and output drive
// - Sixteen routed enables, any to pins
// - Slew bit matters in strong, open drain
// - Port edge flags drive one request line
// - Per-pin edge select: rise, fall, both, none
// - Edge sets status bit and request
// - No level detection in this unit
// - One threshold type per whole port
// - Per-pin input buffer disable, any mode
// - Special pins choose supply or regulated high
// - Paired reference threshold, four choices
`timescale 1ns/1ps
`include "iopc_map.svh"
module iopc_port
  import iopc_pkg::*;
#(
  parameter int PINS   = 8,   // Pins per port
  parameter int OE_BUS = 16   // Routed enable lines
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Port form write: one bit per pin for the selected field
  input  wire logic              port_wr,
  input  wire logic [2:0]        port_sel,
  input  wire logic [PINS-1:0]   port_wdata,
  // Pin form write: one byte for one pin
  input  wire logic              pin_wr,
  input  wire logic [2:0]        pin_idx,
  input  wire logic [7:0]        pin_wdata,
  // Edge select, two bits per pin
  input  wire logic [2*PINS-1:0] edge_sel,
  // Status clear, one bit per pin
  input  wire logic [PINS-1:0]   status_clr,
  // Routed enables and per-pin route choice
  input  wire logic [OE_BUS-1:0] aux_oe_bus,
  input  wire logic [4*PINS-1:0] aux_oe_route,
  input  wire logic [PINS-1:0]   bidir_en,
  input  wire logic [PINS-1:0]   bypass_data,
  // Port threshold type and special pin options
  input  wire logic              lvttl_sel,
  input  wire logic [PINS-1:0]   special_io_pin,
  input  wire logic [PINS-1:0]   pin_in,
  input  wire logic [PINS/2*2-1:0] pair_vth_sel,
  // Pad controls
  output logic [PINS-1:0]        pad_out,
  output logic [PINS-1:0]        pad_oe,
  output logic [PINS-1:0]        pad_pull_up,
  output logic [PINS-1:0]        pad_pull_dn,
  output logic [PINS-1:0]        pad_ibuf_en,
  output logic [PINS-1:0]        pad_slow,
  output logic [PINS-1:0]        pad_reg_high,
  output logic                   pad_lvttl,
  output logic [PINS/2*2-1:0]    pad_vth_sel,
  output logic [PINS-1:0]        pin_value,
  output logic [PINS-1:0]        port_irq_status,
  output logic                   port_irq_unit
);
  // ==================================================
  // Shared settings storage (both forms land here)
  logic [PINS-1:0] port_output_value;  // Output data per pin
  logic [2:0]      pin_drive_code [PINS]; // Drive code per pin
  logic [PINS-1:0] ibuf_dis;           // Input buffer off
  logic [PINS-1:0] slew_select;        // One picks slow edges
  logic [PINS-1:0] bypass_sel;         // Data from routed logic
  logic [PINS-1:0] reg_high;           // Regulated high level
  // ==================================================
  // Input synchronizer and edge history
  logic [PINS-1:0] sync_a;             // First stage, read by sync_b
  logic [PINS-1:0] sync_b;             // Stable sample
  logic [PINS-1:0] prev_b;             // Previous stable sample
  logic [PINS-1:0] edge_hit;           // Configured edge seen
  logic [PINS-1:0] next_status;        // Next status value

  // ==================================================
  // Settings writes, per pin
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_cfg
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          pin_drive_code[g]    <= `IOPC_RST_DM;
          port_output_value[g] <= 1'b0;
          ibuf_dis[g]          <= 1'b0;
          slew_select[g]       <= 1'b0;
          bypass_sel[g]        <= 1'b0;
          reg_high[g]          <= 1'b0;
        end else if (pin_wr && pin_idx == 3'(g)) begin
          // Pin form byte overwrites six settings
          port_output_value[g] <= pin_wdata[`IOPC_PF_OUT];
          pin_drive_code[g]    <=
            pin_wdata[`IOPC_PF_DM_HI:`IOPC_PF_DM_LO];
          ibuf_dis[g]          <= pin_wdata[`IOPC_PF_IBUF_DIS];
          slew_select[g]       <= pin_wdata[`IOPC_PF_SLOW];
          bypass_sel[g]        <= pin_wdata[`IOPC_PF_BYPASS];
          reg_high[g]          <= pin_wdata[`IOPC_PF_REG_HIGH];
        end else if (port_wr) begin
          // Port form: one field, every pin except one taking a pin form write this cycle
          case (port_sel)
            `IOPC_SEL_OUT:      port_output_value[g] <= port_wdata[g];
            `IOPC_SEL_DM0:      pin_drive_code[g][0] <= port_wdata[g];
            `IOPC_SEL_DM1:      pin_drive_code[g][1] <= port_wdata[g];
            `IOPC_SEL_DM2:      pin_drive_code[g][2] <= port_wdata[g];
            `IOPC_SEL_IBUF_DIS: ibuf_dis[g]          <= port_wdata[g];
            `IOPC_SEL_SLOW:     slew_select[g]       <= port_wdata[g];
            `IOPC_SEL_BYPASS:   bypass_sel[g]        <= port_wdata[g];
            default:            reg_high[g]          <= port_wdata[g];
          endcase
        end
      end

      // ==================================================
      // Pad drive decode, registered so outputs come from flops
      logic       dat;     // Effective output data
      logic       oe_hw;   // Routed enable for this pin
      logic [2:0] dm;      // Effective drive code
      logic       rh;      // Regulated high active
      always_comb begin
        dat   = bypass_sel[g] ? bypass_data[g] : port_output_value[g];
        oe_hw = aux_oe_bus[aux_oe_route[4*g +: 4]];
        // Regulated high only on special pins
        rh    = reg_high[g] & special_io_pin[g];
        dm    = pin_drive_code[g];
        // Routed enable low gives digital input
        // Any bus line may feed this pin
        if (bidir_en[g] && !oe_hw)
          dm = `IOPC_DM_DIGITAL_HIZ;
        if (rh && (dm == `IOPC_DM_RES_UP || dm == `IOPC_DM_RES_DOWN ||
                   dm == `IOPC_DM_RES_BOTH))
          dm = `IOPC_DM_DIGITAL_HIZ;
      end

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          pad_out[g]      <= 1'b0;
          pad_oe[g]       <= 1'b0;
          pad_pull_up[g]  <= 1'b0;
          pad_pull_dn[g]  <= 1'b0;
          pad_ibuf_en[g]  <= 1'b0;
          pad_slow[g]     <= 1'b0;
          pad_reg_high[g] <= 1'b0;
        end else begin
          pad_out[g]      <= dat;
          pad_reg_high[g] <= rh;
          pad_ibuf_en[g]  <= (dm != `IOPC_DM_ANALOG_HIZ) & ~ibuf_dis[g];
          // Slew only for strong and open drain
          pad_slow[g]     <= slew_select[g] &
                             (dm == `IOPC_DM_STRONG ||
                              dm == `IOPC_DM_OD_LOW ||
                              dm == `IOPC_DM_OD_HIGH);
          case (iopc_drive_t'(dm))
            IOPC_ANALOG_HIZ, IOPC_DIGITAL_HIZ: begin
              pad_oe[g]      <= 1'b0;
              pad_pull_up[g] <= 1'b0;
              pad_pull_dn[g] <= 1'b0;
            end
            IOPC_RES_UP: begin
              pad_oe[g]      <= ~dat;
              pad_pull_up[g] <= dat;
              pad_pull_dn[g] <= 1'b0;
            end
            IOPC_RES_DOWN: begin
              pad_oe[g]      <= dat;
              pad_pull_up[g] <= 1'b0;
              pad_pull_dn[g] <= ~dat;
            end
            IOPC_OD_LOW: begin
              pad_oe[g]      <= ~dat;
              pad_pull_up[g] <= 1'b0;
              pad_pull_dn[g] <= 1'b0;
            end
            IOPC_OD_HIGH: begin
              pad_oe[g]      <= dat;
              pad_pull_up[g] <= 1'b0;
              pad_pull_dn[g] <= 1'b0;
            end
            IOPC_STRONG: begin
              pad_oe[g]      <= 1'b1;
              pad_pull_up[g] <= 1'b0;
              pad_pull_dn[g] <= 1'b0;
            end
            default: begin
              pad_oe[g]      <= 1'b0;
              pad_pull_up[g] <= dat;
              pad_pull_dn[g] <= ~dat;
            end
          endcase
        end
      end

      // ==================================================
      // Edge detection, edges only since levels need outside logic
      always_comb begin
        case (iopc_edge_t'(edge_sel[2*g +: 2]))
          IOPC_E_RISE: edge_hit[g] = sync_b[g] & ~prev_b[g];
          IOPC_E_FALL: edge_hit[g] = ~sync_b[g] & prev_b[g];
          IOPC_E_BOTH: edge_hit[g] = sync_b[g] ^ prev_b[g];
          default:     edge_hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // ==================================================
  // Pin sampling; pads are asynchronous so two stages first
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a    <= `IOPC_RST_BYTE;
      sync_b    <= `IOPC_RST_BYTE;
      prev_b    <= `IOPC_RST_BYTE;
      pin_value <= `IOPC_RST_BYTE;
    end else begin
      sync_a    <= pin_in;
      sync_b    <= sync_a;
      prev_b    <= sync_b;
      // Read gated by buffer enable
      pin_value <= sync_b & pad_ibuf_en;
    end
  end

  // ==================================================
  // Status and request; a new edge wins over a clear
  // Set status bit on edge
  assign next_status = (port_irq_status & ~status_clr) | edge_hit;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      port_irq_status <= `IOPC_RST_BYTE;
      port_irq_unit   <= 1'b0;
    end else begin
      port_irq_status <= next_status;
      port_irq_unit   <= |next_status;
    end
  end

  // ==================================================
  // Port threshold and pair references
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pad_lvttl   <= 1'b0;
      pad_vth_sel <= '0;
    end else begin
      pad_lvttl   <= lvttl_sel;
      pad_vth_sel <= pair_vth_sel;
    end
  end

  // ==================================================
  // Checks
  // Regulated flag follows special pin choice
  property p_reg_high;
    @(posedge clk_sys) disable iff (sys_rst)
      !special_io_pin[0] |=> !pad_reg_high[0];
  endproperty
  a_reg_high: assert property (p_reg_high)
    else $error("regulated high on ordinary pin");

  property p_irq_follow;
    @(posedge clk_sys) disable iff (sys_rst)
      (|port_irq_status) == port_irq_unit;
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("request disagrees with status");

  property p_rise_sets;
    @(posedge clk_sys) disable iff (sys_rst)
      (edge_sel[1:0] == `IOPC_EDGE_RISE && $rose(sync_b[0]))
        |=> port_irq_status[0];
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("rising edge not flagged");

  property p_none_quiet;
    @(posedge clk_sys) disable iff (sys_rst)
      (edge_sel[1:0] == `IOPC_EDGE_NONE && !port_irq_status[0])
        |=> !port_irq_status[0];
  endproperty
  a_none_quiet: assert property (p_none_quiet)
    else $error("flag set with edges off");

  property p_strong_oe;
    @(posedge clk_sys) disable iff (sys_rst)
      (pin_drive_code[0] == `IOPC_DM_STRONG && !bidir_en[0])
        |=> pad_oe[0];
  endproperty
  a_strong_oe: assert property (p_strong_oe)
    else $error("strong pin not driven");

  property p_hiz_off;
    @(posedge clk_sys) disable iff (sys_rst)
      (pin_drive_code[0] == `IOPC_DM_DIGITAL_HIZ)
        |=> (!pad_oe[0] && !pad_pull_up[0] && !pad_pull_dn[0]);
  endproperty
  a_hiz_off: assert property (p_hiz_off)
    else $error("digital high-Z pin drives");

  property p_bidir_in;
    @(posedge clk_sys) disable iff (sys_rst)
      (bidir_en[0] && !aux_oe_bus[aux_oe_route[3:0]]) |=> !pad_oe[0];
  endproperty
  a_bidir_in: assert property (p_bidir_in)
    else $error("bidirectional pin drives while disabled");

  property p_ibuf_dis;
    @(posedge clk_sys) disable iff (sys_rst)
      ibuf_dis[0] |=> !pad_ibuf_en[0];
  endproperty
  a_ibuf_dis: assert property (p_ibuf_dis)
    else $error("input buffer on while disabled");

  // Pin 4 is watched because the low pins are usually ordinary
  property p_no_pull_reg;
    @(posedge clk_sys) disable iff (sys_rst)
      (reg_high[4] && special_io_pin[4])
        |=> (!pad_pull_up[4] && !pad_pull_dn[4]);
  endproperty
  a_no_pull_reg: assert property (p_no_pull_reg)
    else $error("pull active on regulated pin");

endmodule // iopc_port

/* verif/iopc_pin_model.sv */
// Far-side pin model: resolves each pad from device drive and load
`timescale 1ns/1ps
module iopc_pin_model #(
  parameter int PINS = 8  // Pins per port
) (
  input  wire logic            clk_sys,
  input  wire logic [PINS-1:0] pad_out,     // Device data
  input  wire logic [PINS-1:0] pad_oe,      // Device strong driver
  input  wire logic [PINS-1:0] pad_pull_up, // Device resistor up
  input  wire logic [PINS-1:0] pad_pull_dn, // Device resistor down
  input  wire logic [PINS-1:0] ext_en,      // Outside source drives
  input  wire logic [PINS-1:0] ext_val,     // Outside source level
  output logic [PINS-1:0]      pin_in       // Level seen at the pad
);
  // ==================================================
  // Floating pads
  logic [PINS-1:0] float_val = '0; // Wanders so no stale level is seen
  // Toggle each cycle; a floating pad has no defined level
  always_ff @(posedge clk_sys) begin
    float_val <= ~float_val;
  end
  // ==================================================
  // Pad resolution: strong beats outside, outside beats resistor
  // strong versus resistive drive
  always_comb begin
    for (int n = 0; n < PINS; n++) begin
      if (pad_oe[n]) pin_in[n] = pad_out[n];
      else if (ext_en[n]) pin_in[n] = ext_val[n];
      else if (pad_pull_up[n]) pin_in[n] = 1'b1;
      else if (pad_pull_dn[n]) pin_in[n] = 1'b0;
      else pin_in[n] = float_val[n];
    end
  end
endmodule // iopc_pin_model

/* verif/io_pin_port_control_tb.sv */
// Self-checking bench for the eight-pin port control block
`timescale 1ns/1ps
module io_pin_port_control_tb;
  import iopc_pkg::*;
  // ==================================================
  // Stimulus and observed signals
  logic clk_sys = 0, sys_rst = 1, port_wr = 0, pin_wr = 0, lvttl_sel = 0;
  logic [2:0] port_sel = 0, pin_idx = 0;
  logic [7:0] port_wdata = 0, pin_wdata = 0, status_clr = 0;
  logic [15:0] edge_sel = 0, aux_oe_bus = 0;
  logic [31:0] aux_oe_route = 0;
  logic [7:0] bidir_en = 0, bypass_data = 0, pair_vth_sel = 0;
  logic [7:0] special_io_pin = 8'hF0;      // Straps: upper four special
  logic [7:0] ext_en = 0, ext_val = 0, pin_in;
  logic [7:0] pad_out, pad_oe, pad_pull_up, pad_pull_dn, pad_ibuf_en;
  logic [7:0] pad_slow, pad_reg_high, pad_vth_sel, pin_value, st;
  logic       pad_lvttl, port_irq_unit;
  logic [7:0] cfg [8];                      // Shadow of pin-form bytes
  int num_errors = 0, n_tests = 0, cycles = 0, seed = 18;
  always #12.5 clk_sys = ~clk_sys;
  iopc_port DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .port_wr(port_wr),
    .port_sel(port_sel), .port_wdata(port_wdata), .pin_wr(pin_wr),
    .pin_idx(pin_idx), .pin_wdata(pin_wdata), .edge_sel(edge_sel),
    .status_clr(status_clr), .aux_oe_bus(aux_oe_bus),
    .aux_oe_route(aux_oe_route), .bidir_en(bidir_en),
    .bypass_data(bypass_data), .lvttl_sel(lvttl_sel),
    .special_io_pin(special_io_pin), .pin_in(pin_in),
    .pair_vth_sel(pair_vth_sel), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_pull_dn(pad_pull_dn),
    .pad_ibuf_en(pad_ibuf_en), .pad_slow(pad_slow),
    .pad_reg_high(pad_reg_high), .pad_lvttl(pad_lvttl),
    .pad_vth_sel(pad_vth_sel), .pin_value(pin_value),
    .port_irq_status(st), .port_irq_unit(port_irq_unit));
  iopc_pin_model PART (.clk_sys(clk_sys), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .pad_pull_dn(pad_pull_dn),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  // ==================================================
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d of %0d compares", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard: whole run is under four hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  // One write cycle; pin form is applied after port form so it wins
  task automatic wr(input logic pw, input logic [2:0] ix,
                    input logic [7:0] pd, input logic qw,
                    input logic [2:0] sel, input logic [7:0] qd);
    pin_wr = pw; pin_idx = ix; pin_wdata = pd;
    port_wr = qw; port_sel = sel; port_wdata = qd;
    step(1);
    if (qw) for (int n = 0; n < 8; n++) cfg[n][sel] = qd[n];
    if (pw) cfg[ix] = pd;
  endtask
  // Expected {oe, pull up, pull down, ibuf, slow, regulated} of one pin
  function automatic logic [5:0] exp_pin(input logic [7:0] b,
      input logic sp, input logic bd, input logic en, input logic bp);
    logic [2:0] c;
    logic d, oe, pu, pd, rh;
    c = b[3:1]; d = b[6] ? bp : b[0]; rh = b[7] & sp;
    oe = 0; pu = 0; pd = 0;
    if (rh && (c == 2 || c == 3 || c == 7)) c = 3'h1;
    if (bd && !en) c = 3'h1;
    case (c)
      3'h2: begin pu = d; oe = !d; end
      3'h3: begin oe = d; pd = !d; end
      3'h4: oe = !d;
      3'h5: oe = d;
      3'h6: oe = 1;
      3'h7: begin pu = d; pd = !d; end
      default: ;
    endcase
    return {oe, pu, pd, (c != 0) & !b[4], b[5] & (c >= 4 && c <= 6), rh};
  endfunction
  task automatic check_all();
    logic [5:0] e;
    logic en, d;
    for (int n = 0; n < 8; n++) begin
      en = aux_oe_bus[aux_oe_route[4*n +: 4]];
      d = cfg[n][6] ? bypass_data[n] : cfg[n][0];
      e = exp_pin(cfg[n], special_io_pin[n], bidir_en[n], en, bypass_data[n]);
      check({pad_oe[n], pad_pull_up[n], pad_pull_dn[n], pad_ibuf_en[n],
             pad_slow[n], pad_reg_high[n]}, e);
      if (e[5]) check(pad_out[n], d);
    end
    check(pad_lvttl, lvttl_sel);
    check(pad_vth_sel, pair_vth_sel);
  endtask
  task automatic check_reset();
    check({pad_oe, pad_pull_up, pad_pull_dn, pad_ibuf_en, st}, 0);
    check(pin_value, 0);
  endtask
  // ==================================================
  // Main sequence
  initial begin
    logic [7:0] r;
    logic [2:0] ix, sl;
    foreach (cfg[n]) cfg[n] = 0;
    step(20);
    check_reset();
    sys_rst = 0;
    step(2);
    check_reset();
    // Random configuration through both forms, back to back
    repeat (40) begin
      r = 8'($random(seed)); ix = r[2:0]; sl = r[5:3];
      wr(1, ix, 8'($random(seed)), 0, 0, 0);
      wr(0, 0, 0, 1, sl, 8'($random(seed)));
      r = {cfg[7][sl], cfg[6][sl], cfg[5][sl], cfg[4][sl], cfg[3][sl],
           cfg[2][sl], cfg[1][sl], cfg[0][sl]};
      r[ix] = ~r[ix];
      wr(1, ix, 8'($random(seed)), 1, sl, r);
      pin_wr = 0; port_wr = 0;
      aux_oe_bus = 16'($random(seed)); aux_oe_route = $random(seed);
      bidir_en = 8'($random(seed)); bypass_data = 8'($random(seed));
      lvttl_sel = 1'($random(seed)); pair_vth_sel = 8'($random(seed));
      ext_en = 8'($random(seed)); ext_val = 8'($random(seed));
      step(3);
      check_all();
    end
    // Every pin digital high-Z, driven from outside
    bidir_en = 0; ext_en = 8'hFF; ext_val = 0;
    wr(0, 0, 0, 1, 3'h1, 8'hFF);
    for (int s = 2; s < 8; s++) wr(0, 0, 0, 1, s[2:0], 8'h00);
    port_wr = 0;
    ext_val = 8'hA5;
    step(5);
    check(pin_value, 8'hA5);
    wr(0, 0, 0, 1, 3'h4, 8'h0F);
    port_wr = 0;
    step(5);
    check(pin_value, 8'hA0);
    wr(0, 0, 0, 1, 3'h4, 8'h00);
    port_wr = 0;
    ext_val = 0;
    // Each edge mode in turn on all pins
    for (int m = 0; m < 4; m++) begin
      edge_sel = {8{m[1:0]}}; status_clr = 8'hFF;
      step(5);
      status_clr = 0; ext_val = 8'hFF;
      step(2);
      check(st, 0);
      step(2);
      check(st, (m == 1 || m == 3) ? 8'hFF : 8'h00);
      check(port_irq_unit, (m == 1 || m == 3));
      status_clr = 8'hFF;
      step(1);
      status_clr = 0;
      step(5);
      check(st, 0);
      ext_val = 0;
      step(4);
      check(st, (m == 2 || m == 3) ? 8'hFF : 8'h00);
      check(port_irq_unit, (m == 2 || m == 3));
    end
    // Reset in mid-run drops every setting
    sys_rst = 1;
    step(2);
    check_reset();
    sys_rst = 0;
    foreach (cfg[n]) cfg[n] = 0;
    step(2);
    check_reset();
    check_all();
    test_done();
  end
endmodule // io_pin_port_control_tb
